// File: hw/rtopt_pkg.sv
// Constants, states and register map for the remote terminal option logic.
// Assumes one 200 MHz core clock and a 16-bit word-addressed host register port.
package rtopt_pkg;
    localparam int unsigned AW         = 16;
    localparam int unsigned DW         = 16;
    localparam int unsigned HOLD_DEPTH = 32;
    localparam int unsigned NTERM      = 2;
    // Host register addresses
    localparam logic [AW-1:0] ADDR_CFG_FIRST  = 16'h0017;
    localparam logic [AW-1:0] ADDR_DEF_FIRST  = 16'h001E;
    localparam logic [AW-1:0] ADDR_ALT_FIRST  = 16'h001F;
    localparam logic [AW-1:0] ADDR_CFG_SECOND = 16'h0020;
    localparam logic [AW-1:0] ADDR_DEF_SECOND = 16'h0027;
    localparam logic [AW-1:0] ADDR_ALT_SECOND = 16'h0028;
    // Option bit positions in the configuration register
    localparam int unsigned BIT_BSEP = 8;
    localparam int unsigned BIT_SIMPLIFIED_MODE_PROCESSING = 7;
    localparam int unsigned BIT_TRXB = 6;
    localparam int unsigned BIT_ALTB = 5;
    localparam logic [DW-1:0] CFG_MASK  = 16'h01E0;
    localparam logic [DW-1:0] CFG_RST   = 16'h0000;
    // Device-owned bits of the default BIT word
    localparam int unsigned   BITW_ERR  = 0;
    localparam int unsigned   BITW_OVF  = 1;
    localparam logic [DW-1:0] BITW_DEV  = 16'h0003;
    localparam logic [DW-1:0] BITW_RST  = 16'h0000;
    localparam logic [DW-1:0] ZERO_WORD = 16'h0000;
    // Message sequencer states
    typedef enum logic [2:0] {
        ST_IDLE   = 3'b001,
        ST_RECV   = 3'b010,
        ST_COMMIT = 3'b100
    } rtopt_state_t;
endpackage : rtopt_pkg

// File: hw/rtopt_hold_if.sv
// Interface between the message sequencer and the receive holding buffer.
// Assumes both ends run on the same core clock.
`timescale 1ns/1ps
interface rtopt_hold_if #(parameter int unsigned DEPTH = rtopt_pkg::HOLD_DEPTH);
    localparam int unsigned IW = $clog2(DEPTH);
    logic                    clr;
    logic                    wr_en;
    logic [rtopt_pkg::DW-1:0] wr_data;
    logic                    commit;
    logic                    out_valid;
    logic [IW-1:0]           out_idx;
    logic [rtopt_pkg::DW-1:0] out_data;
    logic                    done;
    logic                    ovf;
    // Sequencer side
    modport ctl (output clr, wr_en, wr_data, commit,
                 input  out_valid, out_idx, out_data, done, ovf);
    // Buffer side
    modport store (input  clr, wr_en, wr_data, commit,
                   output out_valid, out_idx, out_data, done, ovf);
endinterface : rtopt_hold_if

// File: hw/rtopt_hold_buf.sv
// Receive holding buffer: collects words, then drains them one per cycle.
// Assumes clr comes before the first word and commit only after the last.
`timescale 1ns/1ps
module rtopt_hold_buf #(
    parameter int unsigned DEPTH = rtopt_pkg::HOLD_DEPTH
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // Sequencer link
    rtopt_hold_if.store hif
);
    import rtopt_pkg::*;
    localparam int unsigned IW = $clog2(DEPTH);
    localparam logic [IW:0] FULL = (IW+1)'(DEPTH);

    logic [DW-1:0] mem_q [DEPTH];
    logic [IW:0]   count_q;
    logic [IW-1:0] rd_q;
    logic          drain_q;
    logic          ovf_q;
    logic          out_valid_q;
    logic [IW-1:0] out_idx_q;
    logic [DW-1:0] out_data_q;
    logic          done_q;

    // Fill side; words past the end are dropped and flagged
    always_ff @(posedge core_clk)
    begin
        if (rst || hif.clr)
        begin
            count_q <= '0;
            ovf_q   <= 1'b0;
        end
        else if (hif.wr_en)
        begin
            if (count_q == FULL)
                ovf_q <= 1'b1;
            else
            begin
                mem_q[count_q[IW-1:0]] <= hif.wr_data;
                count_q                <= count_q + (IW+1)'(1);
            end
        end
    end

    // Drain side; done marks the last word or an empty commit
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            drain_q <= 1'b0;
            rd_q    <= '0;
            done_q  <= 1'b0;
        end
        else
        begin
            done_q <= 1'b0;
            if (hif.commit)
            begin
                drain_q <= (count_q != '0);
                rd_q    <= '0;
                done_q  <= (count_q == '0);
            end
            else if (drain_q)
            begin
                rd_q <= rd_q + IW'(1);
                if ({1'b0, rd_q} + (IW+1)'(1) == count_q)
                begin
                    drain_q <= 1'b0;
                    done_q  <= 1'b1;
                end
            end
        end
    end

    // Registered output word
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            out_valid_q <= 1'b0;
            out_idx_q   <= '0;
            out_data_q  <= ZERO_WORD;
        end
        else
        begin
            out_valid_q <= drain_q && !hif.commit;
            out_idx_q   <= rd_q;
            out_data_q  <= mem_q[rd_q];
        end
    end

    assign hif.out_valid = out_valid_q;
    assign hif.out_idx   = out_idx_q;
    assign hif.out_data  = out_data_q;
    assign hif.done      = done_q;
    assign hif.ovf       = ovf_q;
endmodule : rtopt_hold_buf

// File: hw/rtopt_term_regs.sv
// One terminal's option register and its two BIT word registers.
// Assumes host writes and status updates come from the core clock domain.
`timescale 1ns/1ps
module rtopt_term_regs #(
    parameter logic [15:0] CFG_ADDR = rtopt_pkg::ADDR_CFG_FIRST,
    parameter logic [15:0] DEF_ADDR = rtopt_pkg::ADDR_DEF_FIRST,
    parameter logic [15:0] ALT_ADDR = rtopt_pkg::ADDR_ALT_FIRST
) (
    // Clock and reset
    input  wire logic                   core_clk,
    input  wire logic                   rst,
    // Host port
    input  wire logic                   wr_en,
    input  wire logic [rtopt_pkg::AW-1:0] addr,
    input  wire logic [rtopt_pkg::DW-1:0] wdata,
    output logic                        rd_hit,
    output logic [rtopt_pkg::DW-1:0]    rd_data,
    // Terminal state
    input  wire logic                   exec_idle,
    input  wire logic                   status_we,
    input  wire logic                   status_err,
    input  wire logic                   status_ovf,
    // Option and BIT word outputs
    output logic                        bsep,
    output logic                        simplified_mode_processing,
    output logic                        trxb,
    output logic                        altb,
    output logic [rtopt_pkg::DW-1:0]    def_word,
    output logic [rtopt_pkg::DW-1:0]    alt_word
);
    import rtopt_pkg::*;

    logic [DW-1:0] cfg_q;
    logic [DW-1:0] def_q;
    logic [DW-1:0] alt_q;
    logic          trx_eff_q;

    // Option bits, own copy per terminal, cleared at reset
    always_ff @(posedge core_clk)
    begin
        if (rst)
            cfg_q <= CFG_RST;
        else if (wr_en && addr == CFG_ADDR)
            cfg_q <= wdata & CFG_MASK;
    end

    // Holding buffer enable only follows while both terminals are stopped
    always_ff @(posedge core_clk)
    begin
        if (rst)
            trx_eff_q <= 1'b0;
        else if (exec_idle)
            trx_eff_q <= cfg_q[BIT_TRXB];
    end

    // Default word: device owns the status bits, host the rest
    always_ff @(posedge core_clk)
    begin
        if (rst)
            def_q <= BITW_RST;
        else
        begin
            if (wr_en && addr == DEF_ADDR)
                def_q[DW-1:2] <= wdata[DW-1:2];
            if (status_we)
            begin
                def_q[BITW_ERR] <= status_err;
                def_q[BITW_OVF] <= status_ovf;
            end
        end
    end

    // Alternate word is fully user defined
    always_ff @(posedge core_clk)
    begin
        if (rst)
            alt_q <= BITW_RST;
        else if (wr_en && addr == ALT_ADDR)
            alt_q <= wdata;
    end

    // Read decode
    always_comb
    begin
        rd_hit  = 1'b1;
        rd_data = ZERO_WORD;
        if (addr == CFG_ADDR)
            rd_data = cfg_q;
        else if (addr == DEF_ADDR)
            rd_data = def_q;
        else if (addr == ALT_ADDR)
            rd_data = alt_q;
        else
            rd_hit = 1'b0;
    end

    assign bsep     = cfg_q[BIT_BSEP];
    assign simplified_mode_processing     = cfg_q[BIT_SIMPLIFIED_MODE_PROCESSING];
    assign trxb     = trx_eff_q;
    assign altb     = cfg_q[BIT_ALTB];
    assign def_word = def_q;
    assign alt_word = alt_q;
endmodule : rtopt_term_regs

// File: hw/rtopt_top.sv
// Option logic for two remote terminals: data placement, holding buffer,
// simplified mode flag and BIT word selection.
// Assumes the protocol engine and host port run on core_clk.
`timescale 1ns/1ps
module rtopt_top (
    // Clock and reset
    input  wire logic                    core_clk,
    input  wire logic                    rst,
    // Host register port
    input  wire logic                    host_wr,
    input  wire logic                    host_rd,
    input  wire logic [rtopt_pkg::AW-1:0] host_addr,
    input  wire logic [rtopt_pkg::DW-1:0] host_wdata,
    output logic [rtopt_pkg::DW-1:0]     host_rdata,
    output logic                         host_rvalid,
    // Terminal execute levels
    input  wire logic                    first_terminal_execute,
    input  wire logic                    second_terminal_execute,
    // Message from protocol engine
    input  wire logic                    msg_start,
    input  wire logic                    msg_term,
    input  wire logic                    msg_bcast,
    input  wire logic                    msg_mode,
    input  wire logic [rtopt_pkg::AW-1:0] msg_rx_base,
    input  wire logic [rtopt_pkg::AW-1:0] msg_bc_base,
    input  wire logic                    word_valid,
    input  wire logic [rtopt_pkg::DW-1:0] word_data,
    input  wire logic                    msg_end,
    input  wire logic                    msg_error,
    // Transmit BIT word request
    input  wire logic                    bitw_req,
    input  wire logic                    bitw_term,
    output logic                         bitw_valid,
    output logic [rtopt_pkg::DW-1:0]     bitw_data,
    // Message status
    output logic                         seq_busy,
    output logic                         mode_simplified,
    // Data memory write port
    output logic                         mem_we,
    output logic [rtopt_pkg::AW-1:0]     mem_addr,
    output logic [rtopt_pkg::DW-1:0]     mem_wdata
);
    import rtopt_pkg::*;
    localparam int unsigned IW = $clog2(HOLD_DEPTH);

    rtopt_state_t  state_q;
    logic          term_q;
    logic          use_hold_q;
    logic [AW-1:0] base_q;
    logic [AW-1:0] widx_q;
    logic          mode_simp_q;
    logic          busy_q;
    logic          mem_we_q;
    logic [AW-1:0] mem_addr_q;
    logic [DW-1:0] mem_wdata_q;
    logic          bitw_valid_q;
    logic [DW-1:0] bitw_data_q;
    logic [DW-1:0] host_rdata_q;
    logic          host_rvalid_q;
    logic          stat_we_q;
    logic          stat_err_q;
    logic          stat_ovf_q;

    logic          exec_idle;
    logic          bsep_w   [NTERM];
    logic          simplified_mode_processing_w   [NTERM];
    logic          trxb_w   [NTERM];
    logic          altb_w   [NTERM];
    logic [DW-1:0] def_w    [NTERM];
    logic [DW-1:0] alt_w    [NTERM];
    logic          hit_w    [NTERM];
    logic [DW-1:0] rdat_w   [NTERM];
    logic          swe_w    [NTERM];
    logic          start_ok;
    logic          end_ok;

    rtopt_hold_if #(.DEPTH(HOLD_DEPTH)) hif ();

    assign exec_idle = !first_terminal_execute && !second_terminal_execute;
    assign start_ok  = msg_start && state_q == ST_IDLE;
    assign end_ok    = msg_end && state_q == ST_RECV;

    // Per-terminal option and BIT word registers
    genvar t;
    generate
        for (t = 0; t < NTERM; t++)
        begin : g_term
            assign swe_w[t] = stat_we_q && term_q == 1'(t);
            rtopt_term_regs #(
                .CFG_ADDR (t == 0 ? ADDR_CFG_FIRST : ADDR_CFG_SECOND),
                .DEF_ADDR (t == 0 ? ADDR_DEF_FIRST : ADDR_DEF_SECOND),
                .ALT_ADDR (t == 0 ? ADDR_ALT_FIRST : ADDR_ALT_SECOND)
            ) u_regs (
                .core_clk   (core_clk),
                .rst        (rst),
                .wr_en      (host_wr),
                .addr       (host_addr),
                .wdata      (host_wdata),
                .rd_hit     (hit_w[t]),
                .rd_data    (rdat_w[t]),
                .exec_idle  (exec_idle),
                .status_we  (swe_w[t]),
                .status_err (stat_err_q),
                .status_ovf (stat_ovf_q),
                .bsep       (bsep_w[t]),
                .simplified_mode_processing       (simplified_mode_processing_w[t]),
                .trxb       (trxb_w[t]),
                .altb       (altb_w[t]),
                .def_word   (def_w[t]),
                .alt_word   (alt_w[t])
            );
        end
    endgenerate

    // Receive holding buffer
    rtopt_hold_buf #(
        .DEPTH (HOLD_DEPTH)
    ) u_hold (
        .core_clk (core_clk),
        .rst      (rst),
        .hif      (hif.store)
    );

    // Holding buffer control
    assign hif.clr     = start_ok;
    assign hif.wr_en   = state_q == ST_RECV && use_hold_q && word_valid;
    assign hif.wr_data = word_data;
    assign hif.commit  = end_ok && use_hold_q && !msg_error && !hif.ovf;

    // Message sequencer
    always_ff @(posedge core_clk)
    begin
        if (rst)
            state_q <= ST_IDLE;
        else
        begin
            case (state_q)
                ST_IDLE:
                begin
                    if (msg_start)
                        state_q <= ST_RECV;
                end
                ST_RECV:
                begin
                    if (hif.commit)
                        state_q <= ST_COMMIT;
                    else if (msg_end)
                        state_q <= ST_IDLE;
                end
                ST_COMMIT:
                begin
                    if (hif.done)
                        state_q <= ST_IDLE;
                end
                default:
                    state_q <= ST_IDLE;
            endcase
        end
    end

    // Message context captured at start
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            term_q     <= 1'b0;
            use_hold_q <= 1'b0;
            base_q     <= '0;
        end
        else if (start_ok)
        begin
            term_q     <= msg_term;
            use_hold_q <= trxb_w[msg_term];
            if (msg_bcast && bsep_w[msg_term])
                base_q <= msg_bc_base;
            else
                base_q <= msg_rx_base;
        end
    end

    // Simplified processing flag for the current mode command
    always_ff @(posedge core_clk)
    begin
        if (rst)
            mode_simp_q <= 1'b0;
        else if (start_ok)
            mode_simp_q <= msg_mode && simplified_mode_processing_w[msg_term];
        else if (state_q == ST_IDLE)
            mode_simp_q <= 1'b0;
    end

    // Direct word index
    always_ff @(posedge core_clk)
    begin
        if (rst || start_ok)
            widx_q <= '0;
        else if (state_q == ST_RECV && word_valid)
            widx_q <= widx_q + AW'(1);
    end

    // Memory write port: direct words or drained held words
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            mem_we_q    <= 1'b0;
            mem_addr_q  <= '0;
            mem_wdata_q <= ZERO_WORD;
        end
        else
        begin
            mem_we_q <= 1'b0;
            if (state_q == ST_RECV && !use_hold_q && word_valid)
            begin
                mem_we_q    <= 1'b1;
                mem_addr_q  <= base_q + widx_q;
                mem_wdata_q <= word_data;
            end
            else if (state_q == ST_COMMIT && hif.out_valid)
            begin
                mem_we_q    <= 1'b1;
                mem_addr_q  <= base_q + AW'(hif.out_idx);
                mem_wdata_q <= hif.out_data;
            end
        end
    end

    // Device status for the default BIT word at message end
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            stat_we_q  <= 1'b0;
            stat_err_q <= 1'b0;
            stat_ovf_q <= 1'b0;
        end
        else
        begin
            stat_we_q  <= end_ok;
            stat_err_q <= msg_error;
            stat_ovf_q <= use_hold_q && hif.ovf;
        end
    end

    // Transmit BIT word answer
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            bitw_valid_q <= 1'b0;
            bitw_data_q  <= ZERO_WORD;
        end
        else
        begin
            bitw_valid_q <= bitw_req;
            if (bitw_req && altb_w[bitw_term])
                bitw_data_q <= alt_w[bitw_term];
            else if (bitw_req)
                bitw_data_q <= def_w[bitw_term];
        end
    end

    // Host read data, one cycle after the strobe
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            host_rvalid_q <= 1'b0;
            host_rdata_q  <= ZERO_WORD;
        end
        else
        begin
            host_rvalid_q <= host_rd;
            if (host_rd && hit_w[0])
                host_rdata_q <= rdat_w[0];
            else if (host_rd && hit_w[1])
                host_rdata_q <= rdat_w[1];
            else if (host_rd)
                host_rdata_q <= ZERO_WORD;
        end
    end

    // Busy flag
    always_ff @(posedge core_clk)
    begin
        if (rst)
            busy_q <= 1'b0;
        else
            busy_q <= start_ok || (state_q != ST_IDLE && !(state_q == ST_RECV && msg_end
                      && !hif.commit) && !(state_q == ST_COMMIT && hif.done));
    end

    assign host_rdata      = host_rdata_q;
    assign host_rvalid     = host_rvalid_q;
    assign bitw_valid      = bitw_valid_q;
    assign bitw_data       = bitw_data_q;
    assign seq_busy        = busy_q;
    assign mode_simplified = mode_simp_q;
    assign mem_we          = mem_we_q;
    assign mem_addr        = mem_addr_q;
    assign mem_wdata       = mem_wdata_q;

    // Checks
    sep_store_a: assert property (@(posedge core_clk) disable iff (rst)
        start_ok && msg_bcast && bsep_w[msg_term] |=> base_q == $past(msg_bc_base))
        else $error("broadcast data not sent to separate buffer");

    shared_store_a: assert property (@(posedge core_clk) disable iff (rst)
        start_ok && !(msg_bcast && bsep_w[msg_term]) |=> base_q == $past(msg_rx_base))
        else $error("data not sent to shared receive buffer");

    simp_mode_a: assert property (@(posedge core_clk) disable iff (rst)
        start_ok && msg_mode |=> mode_simplified == $past(simplified_mode_processing_w[msg_term]))
        else $error("simplified mode flag wrong");

    hold_no_write_a: assert property (@(posedge core_clk) disable iff (rst)
        state_q == ST_RECV && use_hold_q |=> !mem_we)
        else $error("memory written while holding");

    error_discard_a: assert property (@(posedge core_clk) disable iff (rst)
        end_ok && use_hold_q && msg_error |=> state_q == ST_IDLE ##1 !mem_we)
        else $error("errored held message reached memory");

    commit_ok_a: assert property (@(posedge core_clk) disable iff (rst)
        end_ok && use_hold_q && !msg_error && !hif.ovf |=> state_q == ST_COMMIT)
        else $error("good held message not committed");

    bit_default_a: assert property (@(posedge core_clk) disable iff (rst)
        bitw_req && !altb_w[bitw_term] |=> bitw_valid && bitw_data == $past(def_w[bitw_term]))
        else $error("default BIT word not returned");

    bit_alt_a: assert property (@(posedge core_clk) disable iff (rst)
        bitw_req && altb_w[bitw_term] |=> bitw_valid && bitw_data == $past(alt_w[bitw_term]))
        else $error("alternate BIT word not returned");

    dev_status_a: assert property (@(posedge core_clk) disable iff (rst)
        end_ok && !msg_term && term_q == 1'b0 |-> ##2 def_w[0][BITW_ERR] == $past(msg_error, 2))
        else $error("BIT word error status not updated");

    opt_reset_a: assert property (@(posedge core_clk)
        $fell(rst) |-> !bsep_w[0] && !simplified_mode_processing_w[0] && !trxb_w[0] && !altb_w[0]
                       && !bsep_w[1] && !simplified_mode_processing_w[1] && !trxb_w[1] && !altb_w[1])
        else $error("option bits not cleared by reset");
endmodule : rtopt_top

// File: sim/rtopt_bc_model.sv
// Bus controller stand-in: sends commands, data words and BIT requests.
// Assumes the option logic samples on rising core_clk.
`timescale 1ns/1ps
module rtopt_bc_model (
    // Clock and status
    input  wire logic  core_clk,
    input  wire logic  seq_busy,
    // Message link and BIT request
    output logic       msg_start, msg_term, msg_bcast, msg_mode,
    output logic       word_valid, msg_end, msg_error, bitw_req, bitw_term,
    output logic [15:0] msg_rx_base, msg_bc_base, word_data
);
    logic [15:0] sent[$];
    logic [15:0] rxb, bcb;
    // Idle bus at time zero
    initial
    begin
        {msg_start, msg_term, msg_bcast, msg_mode, word_valid} = '0;
        {msg_end, msg_error, bitw_req, bitw_term} = '0;
        {msg_rx_base, msg_bc_base, word_data} = '0;
    end
    // One command, n back-to-back words, end, then wait for idle
    task send(input int t, b, m, n, e);
        @(negedge core_clk);
        rxb = $urandom;
        bcb = $urandom;
        {msg_start, msg_term, msg_bcast, msg_mode} = {1'b1, t[0], b[0], m[0]};
        {msg_rx_base, msg_bc_base} = {rxb, bcb};
        sent.delete();
        @(negedge core_clk);
        msg_start = 0;
        {msg_rx_base, msg_bc_base} = ~{rxb, bcb}; // Stale after sampling
        for (int k = 0; k < n; k++)
        begin
            word_valid = 1;
            word_data = $urandom;
            sent.push_back(word_data);
            @(negedge core_clk);
        end
        word_valid = 0;
        word_data = ~word_data;
        msg_end = 1;
        msg_error = e[0];
        @(negedge core_clk);
        msg_end = 0;
        msg_error = ~msg_error;
        for (int k = 0; k < 200 && seq_busy !== 1'b0; k++) @(negedge core_clk);
    endtask : send
    // Transmit BIT word mode command
    task ask(input int t);
        @(negedge core_clk);
        bitw_req = 1;
        bitw_term = t[0];
        @(negedge core_clk);
        bitw_req = 0;
    endtask : ask
endmodule : rtopt_bc_model

// File: sim/rtopt_tb_top.sv
// Self-checking bench for the remote terminal option logic.
// Assumes rtopt_pkg, the design and the bus controller stand-in compile first.
`timescale 1ns/1ps
module rtopt_tb_top;
    import rtopt_pkg::*;
    logic core_clk = 0, rst = 1, host_wr = 0, host_rd = 0;
    logic first_terminal_execute = 0, second_terminal_execute = 0;
    logic [15:0] host_addr = 0, host_wdata = 0, host_rdata, mem_addr, mem_wdata, bitw_data, d;
    logic host_rvalid, bitw_valid, seq_busy, mode_simplified, mem_we, saw;
    logic msg_start, msg_term, msg_bcast, msg_mode, word_valid, msg_end, msg_error;
    logic bitw_req, bitw_term;
    logic [15:0] msg_rx_base, msg_bc_base, word_data, cfg[2], alt[2], def[2];
    logic [31:0] mq[$];
    int fail_count = 0, check_count = 0, cyc = 0, at_end, t;
    localparam logic [15:0] CA[2] = '{ADDR_CFG_FIRST, ADDR_CFG_SECOND};
    localparam logic [15:0] DA[2] = '{ADDR_DEF_FIRST, ADDR_DEF_SECOND};
    localparam logic [15:0] AA[2] = '{ADDR_ALT_FIRST, ADDR_ALT_SECOND};
    always #2.5 core_clk = ~core_clk;
    rtopt_top uut (.*);
    rtopt_bc_model bcm (.*);
    // Memory write capture, mode flag watch and hang limit
    always @(posedge core_clk)
    begin
        cyc <= cyc + 1;
        if (mem_we === 1'b1) mq.push_back({mem_addr, mem_wdata});
        if (msg_end === 1'b1) at_end = mq.size();
        if (seq_busy === 1'b1 && mode_simplified === 1'b1) saw = 1;
        if (cyc == 20000)
        begin
            fail_count++;
            report_and_stop();
        end
    end
    task chk(input logic [31:0] got, exp);
        check_count++;
        if (got !== exp)
        begin
            fail_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task wr(input logic [15:0] a, v);
        @(negedge core_clk);
        {host_wr, host_addr, host_wdata} = {1'b1, a, v};
        @(negedge core_clk);
        {host_wr, host_wdata} = {1'b0, ~v};
    endtask : wr
    task rd(input logic [15:0] a, exp);
        @(negedge core_clk);
        {host_rd, host_addr} = {1'b1, a};
        @(negedge core_clk);
        host_rd = 0;
        // Read answer stands for this one cycle only
        chk({host_rvalid, host_rdata}, {1'b1, exp});
    endtask : rd
    // Model keeps only the four option bits of each terminal
    task setcfg(input int t, input logic [15:0] v);
        wr(CA[t], v);
        cfg[t] = v & CFG_MASK;
    endtask : setcfg
    task msg(input int t, b, m, n, e);
        logic [15:0] base;
        int c;
        mq.delete();
        saw = 0;
        bcm.send(t, b, m, n, e);
        // Last drained word is written in the cycle busy falls
        @(negedge core_clk);
        base = (b && cfg[t][8]) ? bcm.bcb : bcm.rxb;
        c = (cfg[t][6] && (e || n > 32)) ? 0 : n;
        if (cfg[t][6]) chk(at_end, 0);
        chk(mq.size(), c);
        for (int i = 0; i < c; i++) chk(mq[i], {base + i[15:0], bcm.sent[i]});
        chk(saw, m && cfg[t][7]);
        def[t][1:0] = {cfg[t][6] && n > 32, e[0]};
    endtask : msg
    task bitw(input int t);
        bcm.ask(t);
        // Answer valid stands for one cycle after the request edge
        chk({bitw_valid, bitw_data}, {1'b1, cfg[t][5] ? alt[t] : def[t]});
    endtask : bitw
    task report_and_stop();
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : report_and_stop
    initial
    begin
        d = $urandom(32'hC11F6BF7);
        repeat (4) @(posedge core_clk);
        @(negedge core_clk) rst = 0;
        for (t = 0; t < 2; t++)
        begin
            {cfg[t], alt[t]} = '0;
            rd(CA[t], 0);
            rd(AA[t], 0);
            alt[t] = $urandom;
            wr(AA[t], alt[t]);
            d = $urandom;
            wr(DA[t], d);
            def[t] = d & ~BITW_DEV;
            rd(AA[t], alt[t]);
            rd(DA[t], def[t]);
        end
        rd(16'h0003, 0);
        $display("test registers done");
        // Every option combination on both terminals
        for (int i = 0; i < 32; i++)
        begin
            t = i % 2;
            setcfg(t, 16'((i / 2) << 5) | (16'($urandom) & ~CFG_MASK));
            rd(CA[t], cfg[t]);
            msg(t, (i / 4) % 2, (i / 8 + i) % 2, 1 + $urandom % 6, 0);
            bitw(t);
        end
        $display("test options done");
        // Holding buffer with error, overflow and a full 32 words
        for (t = 0; t < 2; t++)
        begin
            setcfg(t, 16'h0040);
            // Terminals run only after the holding bit has settled
            @(negedge core_clk);
            {first_terminal_execute, second_terminal_execute} = 2'h3;
            msg(t, 0, 0, 4, 1);
            rd(DA[t], def[t]);
            msg(t, 0, 0, 33, 0);
            rd(DA[t], def[t]);
            msg(t, 1, 0, 32, 0);
            {first_terminal_execute, second_terminal_execute} = 2'h0;
        end
        $display("test holding done");
        report_and_stop();
    end
endmodule : rtopt_tb_top
